// ---- design/brc_reset_ctrl.sv ----
// Reset control of a PCI Express to PCI bridge with an APB register port.
//
// Operation
// - Latch straps on fundamental reset rising edge.
// - Start EEPROM download only when EEPROM present.
// - Start link training within 80 ms.
// - Hot reset moves link into DL_DOWN.
// - DL_DOWN clears non-sticky, non-EEPROM register bits.
// - DL_DOWN reinitialises non-sticky, non-EEPROM machines.
// - Hot reset asserts internal secondary bus reset.
// - Secondary reset field set drives pin active.
// - Writing zero to field releases pin.
// - Fundamental reset low clears and holds bus reset.
// - Global reset low initialises everything, drives reset.
module brc_reset_ctrl
	import brc_pkg::*;
#(
	parameter int TRAIN_CYCLES = TRAIN_CYC
) (
	input  wire logic               ref_clk,
	input  wire logic               reset,
	input  wire brc_apb_req_s       apbReq,
	output      brc_apb_resp_s      apbResp,
	input  wire logic               fundResetN,
	input  wire logic               globalResetN,
	input  wire logic [STRAP_W-1:0] strapIn,
	input  wire logic               eepromPresent,
	input  wire logic               eepromDone,
	input  wire logic               hotReset,
	output      logic [STRAP_W-1:0] strapLatched,
	output      logic               eepromStart,
	output      logic               linkTrainStart,
	output      logic               dlDown,
	output      logic               nonStickyClear,
	output      logic               secondaryBusResetN
);

	// ------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------
	if (TRAIN_CYCLES < 4 * SYNC_MARGIN) begin : g_bad_train
		$error("TRAIN_CYCLES too small for the reset synchronisers.");
	end

	localparam logic [31:0] TRAIN_LAST = 32'(TRAIN_CYCLES - SYNC_MARGIN);

	brc_state_s s_ff;
	brc_state_s nxt_s;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic setup;
		logic access;
		logic hitCtrl;
		logic hitStat;
		logic intRst;
		setup   = apbReq.psel && !apbReq.penable;
		access  = apbReq.psel && apbReq.penable;
		hitCtrl = apbReq.paddr == BRIDGE_CTRL_ADDR;
		hitStat = apbReq.paddr == STATUS_ADDR;
		intRst  = 1'b0;
		nxt_s   = s_ff;
		nxt_s.fundS1   = fundResetN;
		nxt_s.fundS2   = s_ff.fundS1;
		nxt_s.fundPrev = s_ff.fundS2 && s_ff.globS2;
		nxt_s.globS1   = globalResetN;
		nxt_s.globS2   = s_ff.globS1;
		nxt_s.strapS1  = strapIn;
		nxt_s.strapS2  = s_ff.strapS1;
		nxt_s.eepromStart    = 1'b0;
		nxt_s.linkTrainStart = 1'b0;
		if (s_ff.eepromBusy && eepromDone) begin
			nxt_s.eepromBusy = 1'b0;
		end
		if (setup) begin
			nxt_s.pslverr = !(hitCtrl || hitStat);
			if (hitCtrl) begin
				nxt_s.prdata = {16'h0000, s_ff.ctrl};
			end else if (hitStat) begin
				nxt_s.prdata = {16'h0000, 3'h0, s_ff.state, s_ff.eepromBusy,
					s_ff.state == ST_DLDOWN, s_ff.strapHeld};
			end else begin
				nxt_s.prdata = 32'h0000_0000;
			end
		end
		if (access && apbReq.pwrite && hitCtrl) begin
			nxt_s.ctrl = apbReq.pwdata[15:0];
		end
		unique case (s_ff.state)
			ST_HELD: begin
				if (s_ff.fundS2 && s_ff.globS2 && !s_ff.fundPrev) begin
					nxt_s.strapHeld = s_ff.strapS2;
					nxt_s.state     = ST_LATCH;
				end
			end
			ST_LATCH: begin
				nxt_s.timer = 32'h0000_0000;
				if (eepromPresent) begin
					nxt_s.eepromStart = 1'b1;
					nxt_s.eepromBusy  = 1'b1;
					nxt_s.state       = ST_LOAD;
				end else begin
					nxt_s.linkTrainStart = 1'b1;
					nxt_s.state          = ST_LINK;
				end
			end
			ST_LOAD: begin
				nxt_s.timer = s_ff.timer + 32'h0000_0001;
				if (!s_ff.eepromBusy || eepromDone || s_ff.timer >= TRAIN_LAST) begin
					nxt_s.linkTrainStart = 1'b1;
					nxt_s.state          = ST_LINK;
				end
			end
			ST_LINK: begin
				if (hotReset) begin
					nxt_s.state = ST_DLDOWN;
				end
			end
			ST_DLDOWN: begin
				nxt_s.ctrl  = CTRL_RESET;
				nxt_s.timer = 32'h0000_0000;
				if (!hotReset) begin
					nxt_s.linkTrainStart = 1'b1;
					nxt_s.state          = ST_LINK;
				end
			end
			default: begin
				nxt_s.state = ST_HELD;
			end
		endcase
		if (!s_ff.fundS2) begin
			nxt_s.state      = ST_HELD;
			nxt_s.ctrl       = CTRL_RESET;
			nxt_s.timer      = 32'h0000_0000;
			nxt_s.eepromBusy = 1'b0;
		end
		if (!s_ff.globS2) begin
			nxt_s.state      = ST_HELD;
			nxt_s.ctrl       = CTRL_RESET;
			nxt_s.timer      = 32'h0000_0000;
			nxt_s.eepromBusy = 1'b0;
			nxt_s.strapHeld  = '0;
		end
		intRst = nxt_s.state == ST_HELD || nxt_s.state == ST_DLDOWN;
		nxt_s.busResetN = !(intRst || nxt_s.ctrl[SEC_RST_BIT]);
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			s_ff <= BRC_STATE_RST;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign apbResp.prdata     = s_ff.prdata;
	assign apbResp.pready     = 1'b1;
	assign apbResp.pslverr    = s_ff.pslverr;
	assign strapLatched       = s_ff.strapHeld;
	assign eepromStart        = s_ff.eepromStart;
	assign linkTrainStart     = s_ff.linkTrainStart;
	assign dlDown             = s_ff.state == ST_DLDOWN;
	assign nonStickyClear     = s_ff.state == ST_HELD || dlDown;
	assign secondaryBusResetN = s_ff.busResetN;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	logic ctrlWr;
	assign ctrlWr = apbReq.psel && apbReq.penable && apbReq.pwrite
		&& apbReq.paddr == BRIDGE_CTRL_ADDR;

	a_strap_capture: assert property (
		s_ff.state == ST_HELD && s_ff.fundS2 && !s_ff.fundPrev && s_ff.globS2
		|=> strapLatched == $past(s_ff.strapS2) && s_ff.state == ST_LATCH)
		else $error("Straps not captured on reset release.");
	a_eeprom_launch: assert property (
		s_ff.state == ST_LATCH && s_ff.fundS2 && s_ff.globS2
		|=> eepromStart == $past(eepromPresent)
			&& linkTrainStart == !$past(eepromPresent))
		else $error("EEPROM download decision wrong.");
	a_train_bound: assert property (
		s_ff.state == ST_LOAD |-> s_ff.timer <= TRAIN_LAST)
		else $error("Link training start exceeded the limit.");
	a_hot_dldown: assert property (
		s_ff.state == ST_LINK && hotReset && s_ff.fundS2 && s_ff.globS2
		|=> dlDown)
		else $error("Hot reset did not enter DL_DOWN.");
	a_dldown_clear: assert property (
		dlDown ##1 dlDown |-> s_ff.ctrl == CTRL_RESET)
		else $error("Control bits not cleared in DL_DOWN.");
	a_dldown_keep: assert property (
		dlDown && s_ff.fundS2 && s_ff.globS2
		|=> $stable(strapLatched) && nonStickyClear == dlDown)
		else $error("Sticky state disturbed in DL_DOWN.");
	a_hot_busrst: assert property (
		dlDown |-> !secondaryBusResetN)
		else $error("Bus reset not driven in DL_DOWN.");
	a_secondary_reset_field_set: assert property (
		ctrlWr && apbReq.pwdata[SEC_RST_BIT] |=> !secondaryBusResetN)
		else $error("Secondary reset field did not drive the pin.");
	a_secondary_reset_field_clear: assert property (
		ctrlWr && !apbReq.pwdata[SEC_RST_BIT] && s_ff.state == ST_LINK
		&& !hotReset && s_ff.fundS2 && s_ff.globS2 |=> secondaryBusResetN)
		else $error("Clearing the field did not release the pin.");
	a_fund_held: assert property (
		!s_ff.fundS2 |=> s_ff.ctrl == CTRL_RESET && !secondaryBusResetN
			&& s_ff.state == ST_HELD)
		else $error("Fundamental reset did not clear the block.");
	a_global_init: assert property (
		!s_ff.globS2 |=> strapLatched == '0 && !secondaryBusResetN
			&& !s_ff.eepromBusy)
		else $error("Global reset did not initialise the block.");
	a_pin_or: assert property (
		secondaryBusResetN == !(s_ff.ctrl[SEC_RST_BIT]
			|| s_ff.state == ST_HELD || dlDown))
		else $error("Pin does not follow its reset sources.");

	c_eeprom_load: cover property (eepromStart ##[1:1000] linkTrainStart);
	c_direct_train: cover property (s_ff.state == ST_LATCH && !eepromPresent);
	c_hot_reset: cover property (dlDown ##1 linkTrainStart);
	c_soft_reset: cover property (ctrlWr && apbReq.pwdata[SEC_RST_BIT]);

endmodule

// ---- design/brc_pkg.sv ----
// Shared constants and types of the bridge reset controller.
package brc_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0]  BRIDGE_CTRL_IDX  = 8'h3e;
	localparam logic [11:0] BRIDGE_CTRL_ADDR = {2'h0, BRIDGE_CTRL_IDX, 2'h0};
	localparam logic [7:0]  STATUS_IDX       = 8'h40;
	localparam logic [11:0] STATUS_ADDR      = {2'h0, STATUS_IDX, 2'h0};
	localparam int          SEC_RST_BIT      = 6;
	localparam logic [15:0] CTRL_RESET       = 16'h0000;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int TRAIN_LIMIT_MS = 80;
	localparam int CLK_KHZ        = 50000;
	localparam int TRAIN_CYC      = TRAIN_LIMIT_MS * CLK_KHZ;
	localparam int SYNC_MARGIN    = 8;
	localparam int STRAP_W        = 8;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_HELD   = 3'h0,
		ST_LATCH  = 3'h1,
		ST_LOAD   = 3'h3,
		ST_LINK   = 3'h2,
		ST_DLDOWN = 3'h6
	} brc_state_e;

	typedef struct packed {
		logic [11:0] paddr;
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] pwdata;
	} brc_apb_req_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} brc_apb_resp_s;

	typedef struct packed {
		logic               fundS1;
		logic               fundS2;
		logic               fundPrev;
		logic               globS1;
		logic               globS2;
		logic [STRAP_W-1:0] strapS1;
		logic [STRAP_W-1:0] strapS2;
		logic [STRAP_W-1:0] strapHeld;
		brc_state_e         state;
		logic [31:0]        timer;
		logic               eepromBusy;
		logic               eepromStart;
		logic               linkTrainStart;
		logic [15:0]        ctrl;
		logic [31:0]        prdata;
		logic               pslverr;
		logic               busResetN;
	} brc_state_s;

	localparam brc_state_s BRC_STATE_RST = '0;

endpackage

// ---- tb/brc_upstream_port.sv ----
// Model of the upstream port that drives fundamental and hot reset.
module brc_upstream_port (
	input  wire logic ref_clk,
	input  wire logic cmdReset,
	input  wire logic cmdHot,
	output logic      fundResetN = 1'b0,
	output logic      hotReset = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;

	// Reset is held low before power or clock is withdrawn.
	always @(posedge ref_clk) begin
		fundResetN <= ~cmdReset;
		hotReset   <= cmdHot & ~cmdReset;
	end
endmodule

// ---- tb/test_bridge_reset_control.sv ----
// Self-checking testbench of the bridge reset controller.
module test_bridge_reset_control import brc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TRN = 64;
	logic ref_clk = 0, reset = 1, globalResetN = 1, cmdReset = 1, cmdHot = 0;
	logic eepromPresent = 0, eepromDone = 0, er;
	logic [STRAP_W-1:0] strapIn = 8'ha5;
	logic [STRAP_W-1:0] strapLatched;
	brc_apb_req_s       req = '0;
	brc_apb_resp_s      resp;
	logic fundResetN, hotReset, secondaryBusResetN, eepromStart;
	logic linkTrainStart, dlDown, nonStickyClear;
	logic [31:0] rd;
	int errors = 0, compares = 0, esCnt = 0, ltsCnt = 0;

	brc_upstream_port i_up (.ref_clk(ref_clk), .cmdReset(cmdReset),
		.cmdHot(cmdHot), .fundResetN(fundResetN), .hotReset(hotReset));
	brc_reset_ctrl #(.TRAIN_CYCLES(TRN)) i_dut (.ref_clk(ref_clk),
		.reset(reset), .apbReq(req), .apbResp(resp),
		.fundResetN(fundResetN), .globalResetN(globalResetN),
		.strapIn(strapIn), .eepromPresent(eepromPresent),
		.eepromDone(eepromDone), .hotReset(hotReset),
		.strapLatched(strapLatched), .eepromStart(eepromStart),
		.linkTrainStart(linkTrainStart), .dlDown(dlDown),
		.nonStickyClear(nonStickyClear),
		.secondaryBusResetN(secondaryBusResetN));

	// ------------------------------------------------------------
	// Clock, pulse counters and shared tasks
	// ------------------------------------------------------------
	initial begin
		forever #10 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		esCnt  += int'(eepromStart === 1'b1);
		ltsCnt += int'(linkTrainStart === 1'b1);
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic waitFor(input bit lts, input int lim, output int n);
		int base;
		base = lts ? ltsCnt : esCnt;
		n = 0;
		while ((lts ? ltsCnt : esCnt) == base && n < lim) begin
			@(negedge ref_clk);
			n++;
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		req <= '{a, 1'b1, 1'b0, w, d};
		@(posedge ref_clk);
		req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (resp.pready !== 1'b1 && n < 50);
		errors += int'(resp.pready !== 1'b1);
		rd = resp.prdata;
		er = resp.pslverr;
		req <= '0;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_fund;
		int n, es;
		es = esCnt;
		idle(2);
		chk(secondaryBusResetN, 0);
		@(posedge ref_clk) cmdReset <= 1'b0;
		waitFor(1, TRN + 8, n);
		chk(n <= TRN + 1, 1);
		chk(esCnt - es, 0);
		@(posedge ref_clk) strapIn <= 8'h3c;
		idle(4);
		chk(strapLatched, 8'ha5);
		apb(0, STATUS_ADDR, 32'h0);
		chk(rd, 32'h0000_08a5);
	endtask
	task automatic t_apb;
		chk(secondaryBusResetN, 1);
		apb(1, BRIDGE_CTRL_ADDR, 32'h0000_0040);
		idle(1);
		chk(secondaryBusResetN, 0);
		apb(0, BRIDGE_CTRL_ADDR, 32'h0);
		chk(rd, 32'h0000_0040);
		apb(1, BRIDGE_CTRL_ADDR, 32'hffff_ffbf);
		idle(1);
		chk(secondaryBusResetN, 1);
		apb(1, 12'h004, 32'h0000_0040);
		chk(er, 1);
		apb(0, BRIDGE_CTRL_ADDR, 32'h0);
		chk(rd, 32'h0000_ffbf);
	endtask
	task automatic t_hot;
		int n;
		@(posedge ref_clk) cmdHot <= 1'b1;
		idle(4);
		chk(dlDown, 1);
		chk(secondaryBusResetN, 0);
		chk(nonStickyClear, 1);
		apb(0, BRIDGE_CTRL_ADDR, 32'h0);
		chk(rd, 32'h0);
		@(posedge ref_clk) cmdHot <= 1'b0;
		waitFor(1, 8, n);
		chk(n < 8, 1);
		chk(dlDown, 0);
		chk(secondaryBusResetN, 1);
	endtask
	task automatic t_eeprom;
		int n, lt;
		apb(1, BRIDGE_CTRL_ADDR, 32'h0000_0040);
		@(posedge ref_clk);
		cmdReset      <= 1'b1;
		eepromPresent <= 1'b1;
		idle(4);
		apb(0, BRIDGE_CTRL_ADDR, 32'h0);
		chk(rd, 32'h0);
		lt = ltsCnt;
		@(posedge ref_clk) cmdReset <= 1'b0;
		waitFor(0, 10, n);
		chk(n < 10, 1);
		idle(3);
		chk(ltsCnt - lt, 0);
		@(posedge ref_clk) eepromDone <= 1'b1;
		@(posedge ref_clk) eepromDone <= 1'b0;
		waitFor(1, 8, n);
		chk(ltsCnt - lt, 1);
		@(posedge ref_clk) eepromPresent <= 1'b0;
	endtask
	task automatic t_limit;
		int n, lt, es;
		@(posedge ref_clk);
		cmdReset      <= 1'b1;
		eepromPresent <= 1'b1;
		idle(4);
		lt = ltsCnt;
		es = esCnt;
		@(posedge ref_clk) cmdReset <= 1'b0;
		waitFor(1, TRN + 8, n);
		chk(esCnt - es, 1);
		chk(ltsCnt - lt, 1);
		chk(n <= TRN + 1, 1);
		@(posedge ref_clk) eepromPresent <= 1'b0;
	endtask
	task automatic t_global;
		int n;
		@(posedge ref_clk) globalResetN <= 1'b0;
		idle(5);
		chk(secondaryBusResetN, 0);
		chk(strapLatched, 8'h00);
		apb(0, BRIDGE_CTRL_ADDR, 32'h0);
		chk(rd, 32'h0);
		@(posedge ref_clk) globalResetN <= 1'b1;
		waitFor(1, TRN + 8, n);
		chk(n <= TRN + 1, 1);
		chk(strapLatched, 8'h3c);
	endtask

	task automatic tally_and_finish;
		if (errors == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge ref_clk);
		reset <= 1'b0;
		t_fund();
		t_apb();
		t_hot();
		t_eeprom();
		t_limit();
		t_global();
		tally_and_finish();
	end
	initial begin
		#200000;
		errors++;
		tally_and_finish();
	end
endmodule
